// >>> bfp_timer.sv
// Purpose: Shared constants and the tick-counting delay timer of the breaker failure pick-up
// Assumes: One processing tick every 5 ms; delays are held in whole ticks
// Notes:   The package sits here so that it compiles before the main module

// ----------------------------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------------------------
package bfp_pkg;
   localparam int MAG_W = 16;
   localparam int TMR_W = 19;
   localparam int RATIO_W = 24;
   localparam int WIDE_W = 32;
   localparam int TICK_MS = 5;
   localparam int RETRIP_DLY_MS = 100;
   localparam int FAIL_DLY_MS = 200;
   localparam logic [TMR_W-1:0] RETRIP_TICKS_DEF = TMR_W'(RETRIP_DLY_MS / TICK_MS);
   localparam logic [TMR_W-1:0] FAIL_TICKS_DEF = TMR_W'(FAIL_DLY_MS / TICK_MS);
   // Magnitudes are in 0.001 In; phase threshold in 0.01 In, residual in 0.001 In
   localparam logic [MAG_W-1:0] PH_THR_DEF = 16'h0014;
   localparam logic [MAG_W-1:0] RES_THR_DEF = 16'h04b0;
   localparam logic [WIDE_W-1:0] PH_THR_SCALE = 32'h0000000a;
   localparam logic [WIDE_W-1:0] RESET_PCT = 32'h00000061;
   localparam logic [WIDE_W-1:0] FULL_PCT = 32'h00000064;
   localparam logic [RATIO_W-1:0] RATIO_MAX = 24'hffffff;
   localparam int NUM_PH = 3;
   localparam int SIG_W = 16;
   localparam int REL_W = 8;

   typedef enum logic [1:0] {
      RES_NONE = 2'h0, RES_ONE = 2'h1, RES_TWO = 2'h2, RES_CALC = 2'h3
   } bfp_res_sel_t;

   typedef enum logic [3:0] {
      MODE_CUR = 4'h0, MODE_DO = 4'h1, MODE_SIG = 4'h2, MODE_CUR_AND_DO = 4'h3,
      MODE_CUR_AND_SIG = 4'h4, MODE_CUR_OR_SIG = 4'h5, MODE_SIG_AND_DO = 4'h6,
      MODE_SIG_OR_DO = 4'h7, MODE_CUR_OR_DO = 4'h8, MODE_ANY = 4'h9, MODE_ALL = 4'ha
   } bfp_mode_t;

   typedef enum logic [2:0] {
      FORCE_NORMAL = 3'h0, FORCE_START = 3'h1, FORCE_RETRIP = 3'h2,
      FORCE_FAIL = 3'h3, FORCE_BLOCKED = 3'h4
   } bfp_force_t;

   typedef enum logic [4:0] {
      STS_NORMAL = 5'h01, STS_START = 5'h02, STS_RETRIP = 5'h04,
      STS_FAIL = 5'h08, STS_BLOCKED = 5'h10
   } bfp_status_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1, ST_START = 3'h2, ST_BLOCKED = 3'h4
   } bfp_state_t;
endpackage : bfp_pkg

`timescale 1ns/10ps

// ----------------------------------------------------------------------------------------------
// Delay timer
// ----------------------------------------------------------------------------------------------
module bfp_timer
   import bfp_pkg::*;
(
   input logic sys_clk,
   input logic rst_n,
   input logic clk_en,
   input logic tick,
   input logic run,
   input logic [TMR_W-1:0] delay,
   output logic expired
);
   logic [TMR_W-1:0] count_r;
   logic [TMR_W-1:0] count_nxt;
   logic expired_r;

   assign count_nxt = count_r + TMR_W'(1);
   assign expired = expired_r;

   // Cleared at once when the run condition drops, not on the next tick
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= '0;
      end else if (clk_en) begin
         if (!run) begin
            count_r <= '0;
         end else if (tick && !expired_r) begin
            count_r <= count_nxt;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         expired_r <= 1'b0;
      end else if (clk_en) begin
         if (!run) begin
            expired_r <= 1'b0;
         end else if (tick && (count_nxt >= delay)) begin
            expired_r <= 1'b1;
         end
      end
   end
endmodule : bfp_timer

// >>> bfp_pickup.sv
// Purpose: Breaker failure pick-up, trigger selection, blocking and retrip/failure timing
// Assumes: Magnitudes and phasor parts refreshed once per tick; inputs synchronous to sys_clk
// Notes:   All settings are plain ports; group settings load on group_switch

`timescale 1ns/10ps

// Functional notes
// [R01] Use fundamental magnitudes of three phases and residuals, refreshed every 5 ms.
// [R02] Residual source is none, input one, input two or computed; default none.
// [R03] Computed residual is derived from the three phase current phasors.
// [R04] Ratio of magnitude to threshold is computed for each phase and residual.
// [R05] Current pick-up asserts when any phase magnitude exceeds the phase threshold.
// [R06] Release at 97 percent of the threshold gives hysteresis.
// [R07] One phase threshold is shared by all three phases.
// [R08] Phase threshold in 0.01 per unit steps, default 0.20.
// [R09] Residual threshold in 0.001 per unit steps, default 1.200.
// [R10] Mode picks current, signals, relays or their AND/OR mixes; default current.
// [R11] Masked trip events start the countdown only in modes with signals.
// [R12] Masked relay states start the countdown only in modes with relays.
// [R13] Status override forces normal/start/retrip/failure/blocked while forcing is enabled.
// [R14] Override and monitor masks are static, unaffected by group switching.
// [R15] Thresholds, mode and delays change while running, applied on group switch.
// [R16] Retrip after its delay, 5 ms steps, default 0.100 s, can be disabled.
// [R17] Failure output after its delay, default 0.200 s; same pick-up starts both.
// [R18] Block at pick-up gives blocked; later block releases start.
// [R19] Comparisons, combining and timers advance once per 5 ms tick.
module bfp_pickup
   import bfp_pkg::*;
(
   input logic sys_clk,
   input logic rst_n,
   input logic clk_en,
   input logic tick,
   input logic [MAG_W-1:0] phase_a_current,
   input logic [MAG_W-1:0] phase_b_current,
   input logic [MAG_W-1:0] phase_c_current,
   input logic signed [MAG_W-1:0] phase_a_re,
   input logic signed [MAG_W-1:0] phase_a_im,
   input logic signed [MAG_W-1:0] phase_b_re,
   input logic signed [MAG_W-1:0] phase_b_im,
   input logic signed [MAG_W-1:0] phase_c_re,
   input logic signed [MAG_W-1:0] phase_c_im,
   input logic [MAG_W-1:0] residual_input_one,
   input logic [MAG_W-1:0] residual_input_two,
   input logic [MAG_W-1:0] phase_pickup_threshold,
   input logic [MAG_W-1:0] residual_pickup_threshold,
   input logic [1:0] residual_source_select,
   input logic [3:0] operating_mode,
   input logic retrip_enable,
   input logic [TMR_W-1:0] retrip_delay_ticks,
   input logic [TMR_W-1:0] failure_delay_ticks,
   input logic group_switch,
   input logic [SIG_W-1:0] trip_events,
   input logic [SIG_W-1:0] signal_monitor_mask,
   input logic [REL_W-1:0] relay_states,
   input logic [REL_W-1:0] relay_monitor_mask,
   input logic force_enable,
   input logic [2:0] status_override,
   input logic block_in,
   output logic [RATIO_W-1:0] phase_a_ratio,
   output logic [RATIO_W-1:0] phase_b_ratio,
   output logic [RATIO_W-1:0] phase_c_ratio,
   output logic [RATIO_W-1:0] residual_ratio,
   output logic current_pickup,
   output logic start_out,
   output logic retrip_out,
   output logic breaker_failure_output,
   output logic blocked_out,
   output logic [4:0] status
);
   // ------------------------------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------------------------------
   // Ratio in 0.01 steps; zero threshold saturates rather than dividing by zero
   function automatic logic [RATIO_W-1:0] ratio_f(input logic [WIDE_W-1:0] num,
                                                  input logic [WIDE_W-1:0] den);
      logic [WIDE_W-1:0] q;
      q = '0;
      if (den == '0) begin
         return RATIO_MAX;
      end
      q = num / den;
      return (q > WIDE_W'(RATIO_MAX)) ? RATIO_MAX : q[RATIO_W-1:0];
   endfunction : ratio_f

   // Next pick-up level with 97 percent release hysteresis; thr is in 0.001 In
   function automatic logic hyst_f(input logic [MAG_W-1:0] mag, input logic [WIDE_W-1:0] thr,
                                   input logic cur);
      logic [WIDE_W-1:0] m;
      m = WIDE_W'(mag);
      if (m > thr) begin
         return 1'b1;
      end
      if ((m * FULL_PCT) < (thr * RESET_PCT)) begin
         return 1'b0;
      end
      return cur;
   endfunction : hyst_f

   function automatic logic [MAG_W:0] abs_f(input logic signed [MAG_W+1:0] v);
      logic [MAG_W+1:0] a;
      a = v[MAG_W+1] ? (MAG_W+2)'(-v) : v;
      return a[MAG_W+1] ? {(MAG_W+1){1'b1}} : a[MAG_W:0];
   endfunction : abs_f

   // ------------------------------------------------------------------------------------------
   // Group-dependent settings
   // ------------------------------------------------------------------------------------------
   logic [MAG_W-1:0] ph_thr_r;
   logic [MAG_W-1:0] res_thr_r;
   bfp_res_sel_t res_sel_r;
   bfp_mode_t mode_r;
   logic retrip_en_r;
   logic [TMR_W-1:0] retrip_dly_r;
   logic [TMR_W-1:0] fail_dly_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_thr_r <= PH_THR_DEF; // R08
         res_thr_r <= RES_THR_DEF; // R09
         res_sel_r <= RES_NONE; // R02
         mode_r <= MODE_CUR; // R10
         retrip_en_r <= 1'b1;
         retrip_dly_r <= RETRIP_TICKS_DEF; // R16
         fail_dly_r <= FAIL_TICKS_DEF; // R17
      end else if (clk_en && group_switch) begin
         ph_thr_r <= phase_pickup_threshold; // R15
         res_thr_r <= residual_pickup_threshold;
         res_sel_r <= bfp_res_sel_t'(residual_source_select);
         mode_r <= bfp_mode_t'(operating_mode);
         retrip_en_r <= retrip_enable;
         retrip_dly_r <= retrip_delay_ticks;
         fail_dly_r <= failure_delay_ticks;
      end
   end

   // ------------------------------------------------------------------------------------------
   // Measurement and pick-up
   // ------------------------------------------------------------------------------------------
   logic [MAG_W-1:0] ph_mag [NUM_PH];
   logic [NUM_PH-1:0] ph_pick_r;
   logic [RATIO_W-1:0] ph_ratio_r [NUM_PH];
   logic [WIDE_W-1:0] ph_thr_w;
   logic signed [MAG_W+1:0] sum_re;
   logic signed [MAG_W+1:0] sum_im;
   logic [MAG_W:0] abs_re;
   logic [MAG_W:0] abs_im;
   logic [MAG_W+1:0] calc_est;
   logic [MAG_W-1:0] calc_mag;
   logic [MAG_W-1:0] res_mag;
   logic res_pick_r;
   logic [RATIO_W-1:0] res_ratio_r;
   logic proc;

   assign proc = clk_en && tick; // R19
   assign ph_mag[0] = phase_a_current; // R01
   assign ph_mag[1] = phase_b_current;
   assign ph_mag[2] = phase_c_current;
   assign ph_thr_w = WIDE_W'(ph_thr_r) * PH_THR_SCALE; // R07

   // Vector sum of phases; magnitude by max + min/2, within about 12 percent
   assign sum_re = (MAG_W+2)'(phase_a_re) + (MAG_W+2)'(phase_b_re) + (MAG_W+2)'(phase_c_re); // R03
   assign sum_im = (MAG_W+2)'(phase_a_im) + (MAG_W+2)'(phase_b_im) + (MAG_W+2)'(phase_c_im);
   assign abs_re = abs_f(sum_re);
   assign abs_im = abs_f(sum_im);
   assign calc_est = (abs_re > abs_im) ? ((MAG_W+2)'(abs_re) + (MAG_W+2)'(abs_im >> 1))
                                       : ((MAG_W+2)'(abs_im) + (MAG_W+2)'(abs_re >> 1));
   assign calc_mag = (calc_est > (MAG_W+2)'({MAG_W{1'b1}})) ? {MAG_W{1'b1}} : calc_est[MAG_W-1:0];

   always_comb begin
      if (res_sel_r == RES_ONE) begin // R02
         res_mag = residual_input_one;
      end else if (res_sel_r == RES_TWO) begin
         res_mag = residual_input_two;
      end else if (res_sel_r == RES_CALC) begin
         res_mag = calc_mag; // R03
      end else begin
         res_mag = '0;
      end
   end

   for (genvar i = 0; i < NUM_PH; i++) begin : g_phase
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            ph_pick_r[i] <= 1'b0;
            ph_ratio_r[i] <= '0;
         end else if (proc) begin
            ph_pick_r[i] <= hyst_f(ph_mag[i], ph_thr_w, ph_pick_r[i]); // R05 R06
            ph_ratio_r[i] <= ratio_f(WIDE_W'(ph_mag[i]) * FULL_PCT, ph_thr_w); // R04
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         res_pick_r <= 1'b0;
         res_ratio_r <= '0;
      end else if (proc) begin
         res_pick_r <= (res_sel_r != RES_NONE) &&
                       hyst_f(res_mag, WIDE_W'(res_thr_r), res_pick_r); // R02 R06
         res_ratio_r <= (res_sel_r == RES_NONE) ? '0 :
                        ratio_f(WIDE_W'(res_mag) * FULL_PCT, WIDE_W'(res_thr_r)); // R04
      end
   end

   // ------------------------------------------------------------------------------------------
   // Criterion and blocking
   // ------------------------------------------------------------------------------------------
   logic cur_c;
   logic sig_c;
   logic dout_c;
   logic crit;
   bfp_state_t state_r;

   assign cur_c = (|ph_pick_r) || res_pick_r; // R05
   assign sig_c = |(trip_events & signal_monitor_mask); // R11 R14
   assign dout_c = |(relay_states & relay_monitor_mask); // R12 R14

   always_comb begin
      case (mode_r) // R10 R11 R12
         MODE_DO: crit = dout_c;
         MODE_SIG: crit = sig_c;
         MODE_CUR_AND_DO: crit = cur_c && dout_c;
         MODE_CUR_AND_SIG: crit = cur_c && sig_c;
         MODE_CUR_OR_SIG: crit = cur_c || sig_c;
         MODE_SIG_AND_DO: crit = sig_c && dout_c;
         MODE_SIG_OR_DO: crit = sig_c || dout_c;
         MODE_CUR_OR_DO: crit = cur_c || dout_c;
         MODE_ANY: crit = cur_c || sig_c || dout_c;
         MODE_ALL: crit = cur_c && sig_c && dout_c;
         default: crit = cur_c;
      endcase
   end

   // Blocked holds until the criterion drops; a block during start returns to idle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else if (proc) begin
         case (state_r)
            ST_IDLE: begin
               if (crit) begin
                  state_r <= block_in ? ST_BLOCKED : ST_START; // R18
               end
            end
            ST_START: begin
               if (!crit || block_in) begin
                  state_r <= ST_IDLE; // R18
               end
            end
            ST_BLOCKED: begin
               if (!crit) begin
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------------------------------
   // Timers and outputs
   // ------------------------------------------------------------------------------------------
   logic run;
   logic retrip_done;
   logic fail_done;
   bfp_status_t sts_nxt;

   assign run = (state_r == ST_START); // R17

   bfp_timer u_retrip_tmr (
      .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .tick(tick), .run(run),
      .delay(retrip_dly_r), .expired(retrip_done) // R16
   );

   bfp_timer u_fail_tmr (
      .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .tick(tick), .run(run),
      .delay(fail_dly_r), .expired(fail_done) // R17
   );

   always_comb begin
      if (force_enable) begin
         case (bfp_force_t'(status_override)) // R13
            FORCE_START: sts_nxt = STS_START;
            FORCE_RETRIP: sts_nxt = STS_RETRIP;
            FORCE_FAIL: sts_nxt = STS_FAIL;
            FORCE_BLOCKED: sts_nxt = STS_BLOCKED;
            default: sts_nxt = STS_NORMAL;
         endcase
      end else if (state_r == ST_BLOCKED) begin
         sts_nxt = STS_BLOCKED; // R18
      end else if (run && fail_done) begin
         sts_nxt = STS_FAIL; // R17
      end else if (run && retrip_done && retrip_en_r) begin
         sts_nxt = STS_RETRIP; // R16
      end else if (run) begin
         sts_nxt = STS_START;
      end else begin
         sts_nxt = STS_NORMAL;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= STS_NORMAL;
         start_out <= 1'b0;
         retrip_out <= 1'b0;
         breaker_failure_output <= 1'b0;
         blocked_out <= 1'b0;
         current_pickup <= 1'b0;
      end else if (clk_en) begin
         status <= sts_nxt;
         start_out <= (sts_nxt != STS_NORMAL) && (sts_nxt != STS_BLOCKED);
         retrip_out <= force_enable ? (sts_nxt == STS_RETRIP) :
                       (run && retrip_done && retrip_en_r); // R16
         breaker_failure_output <= (sts_nxt == STS_FAIL); // R17
         blocked_out <= (sts_nxt == STS_BLOCKED); // R18
         current_pickup <= cur_c;
      end
   end

   assign phase_a_ratio = ph_ratio_r[0];
   assign phase_b_ratio = ph_ratio_r[1];
   assign phase_c_ratio = ph_ratio_r[2];
   assign residual_ratio = res_ratio_r;

   // ------------------------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   tick_gate_a: assert property (!proc |=> $stable(state_r)) // R19
      else $error("state moved without a tick");
   block_entry_a: assert property (proc && state_r == ST_IDLE && crit && block_in
                                   |=> state_r == ST_BLOCKED) // R18
      else $error("pick-up under block did not block");
   start_entry_a: assert property (proc && state_r == ST_IDLE && crit && !block_in
                                   |=> state_r == ST_START
                                   ##1 (!$past(clk_en) || start_out || $past(force_enable))) // R18
      else $error("pick-up without block did not start");
   phase_set_a: assert property (proc && WIDE_W'(phase_a_current) > ph_thr_w
                                 |=> ph_pick_r[0] ##1 (!$past(clk_en) || current_pickup)) // R05
      else $error("phase a above threshold not picked up");
   phase_hold_a: assert property (proc && ph_pick_r[0] &&
                                  (WIDE_W'(phase_a_current) * FULL_PCT) >= (ph_thr_w * RESET_PCT)
                                  |=> ph_pick_r[0]) // R06
      else $error("released above reset ratio");
   res_none_a: assert property (proc && res_sel_r == RES_NONE |=> !res_pick_r) // R02
      else $error("residual picked up with source unused");
   retrip_off_a: assert property (clk_en && !force_enable && !retrip_en_r |=> !retrip_out) // R16
      else $error("retrip while disabled");
   fail_out_a: assert property (clk_en && !force_enable && run && fail_done
                                |=> breaker_failure_output && status == STS_FAIL) // R17
      else $error("failure delay elapsed without output");
   fail_quiet_a: assert property (clk_en && !force_enable && !run |=> !breaker_failure_output) // R17
      else $error("failure output without start");
   group_load_a: assert property (clk_en && group_switch
                                  |=> ph_thr_r == $past(phase_pickup_threshold)) // R15
      else $error("group switch did not load threshold");
   force_a: assert property (clk_en && force_enable &&
                             status_override == 3'(FORCE_BLOCKED) |=> blocked_out) // R13
      else $error("forced blocked not shown");

   start_seen_c: cover property (proc && state_r == ST_IDLE && crit && !block_in);
   blocked_seen_c: cover property (state_r == ST_BLOCKED);
   failure_seen_c: cover property (breaker_failure_output && !force_enable);
   retrip_seen_c: cover property (retrip_out && !breaker_failure_output);
endmodule : bfp_pickup

// >>> bfp_meas_model.sv
// Purpose: Measurement front end model, issues the processing tick
// Assumes: One tick per TICK_CYCLES clocks stands for one 5 ms step
// Notes:   Bench holds magnitudes steady between ticks
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Tick source
// ----------------------------------------------------------------
module bfp_meas_model
   import bfp_pkg::*;
#(
   parameter int TICK_CYCLES = 1
)
(
   input logic sys_clk,
   input logic rst_n,
   output logic tick
);
   logic [15:0] cnt_r;
   // Short tick spacing keeps timer runs brief
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt_r == 16'(TICK_CYCLES - 1)) begin
         cnt_r <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule : bfp_meas_model

// >>> bfp_pickup_tb.sv
// Purpose: Self-checking bench of the breaker failure pick-up
// Assumes: Tick every clock, so delays count in clocks
// Notes:   Timer checks allow one clock of pipeline slack
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, e); end end
module bfp_pickup_tb
   import bfp_pkg::*;
;
   logic sys_clk = 0, rst_n = 0, clk_en = 1, tick, grp = 0, ren = 1, fen = 0, blk = 0;
   logic [MAG_W-1:0] pa = 0, pb = 0, pc = 0, r1 = 0, r2 = 0, thr = 16'h0014, rthr = 16'h04b0;
   logic signed [MAG_W-1:0] are = 0, aim = 0;
   logic [1:0] src = 0;
   logic [3:0] mode = 0;
   logic [TMR_W-1:0] rdly = 19'h00014, fdly = 19'h00028;
   logic [SIG_W-1:0] trp = 0, smsk = 16'h0002;
   logic [REL_W-1:0] rel = 0, rmsk = 8'h04;
   logic [2:0] ovr = 0;
   logic [RATIO_W-1:0] ra, rb, rc, rr;
   logic cp, st, rt, bf, bo;
   logic [4:0] status;
   int err_total = 0, total_checks = 0, cyc = 0, n;
   always #5 sys_clk = ~sys_clk;
   bfp_meas_model #(.TICK_CYCLES(1)) i_bfp_meas_model (.sys_clk(sys_clk), .rst_n(rst_n),
      .tick(tick));
   bfp_pickup i_bfp_pickup (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .tick(tick),
      .phase_a_current(pa), .phase_b_current(pb), .phase_c_current(pc), .phase_a_re(are),
      .phase_a_im(aim), .phase_b_re(16'sh0000), .phase_b_im(16'sh0000),
      .phase_c_re(16'sh0000), .phase_c_im(16'sh0000), .residual_input_one(r1),
      .residual_input_two(r2), .phase_pickup_threshold(thr), .residual_pickup_threshold(rthr),
      .residual_source_select(src), .operating_mode(mode), .retrip_enable(ren),
      .retrip_delay_ticks(rdly), .failure_delay_ticks(fdly), .group_switch(grp),
      .trip_events(trp), .signal_monitor_mask(smsk), .relay_states(rel),
      .relay_monitor_mask(rmsk), .force_enable(fen), .status_override(ovr), .block_in(blk),
      .phase_a_ratio(ra), .phase_b_ratio(rb), .phase_c_ratio(rc), .residual_ratio(rr),
      .current_pickup(cp), .start_out(st), .retrip_out(rt), .breaker_failure_output(bf),
      .blocked_out(bo), .status(status));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task tk(input int k);
      repeat (k) @(posedge sys_clk);
   endtask : tk
   task chk_at(input int k);
      tk(k);
      @(negedge sys_clk);
   endtask : chk_at
   task grp_load();
      tk(1);
      grp <= 1'b1;
      tk(1);
      grp <= 1'b0;
   endtask : grp_load
   task done(input string nm);
      $display("test %s finished, mismatches so far %0d", nm, err_total);
   endtask : done
   task conclude();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   function logic crit(input logic [3:0] m, input logic c, input logic s, input logic d);
      case (m)
         4'h1: crit = d;
         4'h2: crit = s;
         4'h3: crit = c & d;
         4'h4: crit = c & s;
         4'h5: crit = c | s;
         4'h6: crit = s & d;
         4'h7: crit = s | d;
         4'h8: crit = c | d;
         4'h9: crit = c | s | d;
         4'ha: crit = c & s & d;
         default: crit = c;
      endcase
   endfunction : crit
   // Hang guard, well above the planned run length
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      tk(10);
      rst_n <= 1'b1;
      chk_at(4);
      `CHK(status, 5'h01)
      `CHK(rr, 24'h000000)
      done("reset");
      tk(1);
      clk_en <= 1'b0;
      pa <= 16'h0190;
      chk_at(6);
      `CHK(cp, 1'b0)
      tk(1);
      clk_en <= 1'b1;
      chk_at(6);
      `CHK(cp, 1'b1)
      tk(1);
      pa <= 16'h0000;
      chk_at(8);
      done("enable");
      for (int k = 0; k < 5; k++) begin
         tk(1);
         fen <= 1'b1;
         ovr <= 3'(k);
         chk_at(3);
         `CHK(status, 5'(5'h01 << k))
      end
      tk(1);
      fen <= 1'b0;
      ovr <= 3'h2;
      chk_at(3);
      `CHK(status, 5'h01)
      done("force");
      tk(1);
      pa <= 16'h0190;
      pb <= 16'h00c8;
      pc <= 16'h0258;
      chk_at(6);
      `CHK(cp, 1'b1)
      `CHK(ra, 24'h0000c8)
      `CHK(rb, 24'h000064)
      `CHK(rc, 24'h00012c)
      tk(1);
      pa <= 16'h00c3;
      pc <= 16'h00c3;
      chk_at(6);
      `CHK(cp, 1'b1)
      tk(1);
      pa <= 16'h00be;
      pb <= 16'h00be;
      pc <= 16'h00be;
      chk_at(6);
      `CHK(cp, 1'b0)
      tk(1);
      thr <= 16'h000a;
      pa <= 16'h0096;
      chk_at(6);
      `CHK(cp, 1'b0)
      grp_load();
      chk_at(6);
      `CHK(cp, 1'b1)
      `CHK(ra, 24'h000096)
      tk(1);
      thr <= 16'h0014;
      pa <= 16'h0000;
      pb <= 16'h0000;
      pc <= 16'h0000;
      grp_load();
      done("phase");
      tk(1);
      src <= 2'h1;
      r1 <= 16'h0960;
      grp_load();
      chk_at(6);
      `CHK(cp, 1'b1)
      `CHK(rr, 24'h0000c8)
      tk(1);
      src <= 2'h2;
      grp_load();
      chk_at(6);
      `CHK(cp, 1'b0)
      tk(1);
      src <= 2'h3;
      are <= 16'sh05dc;
      grp_load();
      chk_at(6);
      `CHK(cp, 1'b1)
      tk(1);
      src <= 2'h0;
      are <= 16'sh0000;
      r1 <= 16'h0000;
      grp_load();
      done("residual");
      for (int m = 0; m < 11; m++) begin
         for (int j = 0; j < 8; j++) begin
            tk(1);
            mode <= 4'(m);
            pa <= 16'h0000;
            trp <= 16'h0001;
            rel <= 8'h00;
            grp_load();
            tk(8);
            pa <= j[0] ? 16'h0190 : 16'h0000;
            trp <= j[1] ? 16'h0003 : 16'h0001;
            rel <= j[2] ? 8'h04 : 8'h0b;
            chk_at(8);
            `CHK(st, crit(4'(m), j[0], j[1], j[2]))
         end
      end
      tk(1);
      smsk <= 16'h0004;
      chk_at(8);
      `CHK(st, 1'b0)
      tk(1);
      smsk <= 16'h0002;
      mode <= 4'h0;
      trp <= 16'h0000;
      rel <= 8'h00;
      pa <= 16'h0000;
      rdly <= 19'h00003;
      fdly <= 19'h00006;
      grp_load();
      done("modes");
      tk(8);
      pa <= 16'h0190;
      n = 0;
      while (st !== 1'b1 && n < 20) begin
         chk_at(1);
         n++;
      end
      n = 0;
      while (rt !== 1'b1 && n < 20) begin
         chk_at(1);
         n++;
      end
      `CHK(n >= 2 && n <= 4, 1'b1)
      while (bf !== 1'b1 && n < 20) begin
         chk_at(1);
         n++;
      end
      `CHK(n >= 5 && n <= 7, 1'b1)
      chk_at(1);
      `CHK(status, 5'h08)
      tk(1);
      pa <= 16'h0000;
      ren <= 1'b0;
      grp_load();
      chk_at(6);
      `CHK(bf, 1'b0)
      tk(1);
      pa <= 16'h0190;
      chk_at(20);
      `CHK(rt, 1'b0)
      `CHK(bf, 1'b1)
      done("timers");
      tk(1);
      pa <= 16'h0000;
      chk_at(8);
      tk(1);
      blk <= 1'b1;
      pa <= 16'h0190;
      chk_at(8);
      `CHK(bo, 1'b1)
      `CHK(st, 1'b0)
      `CHK(status, 5'h10)
      tk(1);
      blk <= 1'b0;
      pa <= 16'h0000;
      chk_at(8);
      tk(1);
      pa <= 16'h0190;
      chk_at(8);
      `CHK(st, 1'b1)
      tk(1);
      blk <= 1'b1;
      chk_at(8);
      `CHK(st, 1'b0)
      `CHK(bo, 1'b1)
      done("block");
      conclude();
   end
endmodule : bfp_pickup_tb
